// [core/single_pin_magnet_command_input.sv]
`timescale 1ns/1ps
package magnet_cmd_pkg;
	// Clock rate, counter width and converter sample width
	localparam int CLK_MHZ = 250;
	localparam int TIMER_W = 32;
	localparam int ADC_W = 13;

	// Pulse width windows in microseconds
	localparam int OFF_MIN_US = 800;
	localparam int OFF_MAX_US = 1200;
	localparam int ON_MIN_US = 1600;
	localparam int ON_MAX_US = 1900;
	localparam int FORCE_MIN_US = 2100;
	localparam int FORCE_MAX_US = 2500;

	// Carrier period window: 400 Hz down to 40 Hz
	localparam int PER_MIN_US = 2500;
	localparam int PER_MAX_US = 25000;

	// Force hold time for fault clearing, and level debounce
	localparam int HOLD_MS = 3000;
	localparam int DEBOUNCE_MS = 20;

	// Derived cycle counts
	localparam logic [TIMER_W-1:0] OFF_MIN_CYC =
		TIMER_W'(OFF_MIN_US * CLK_MHZ);
	localparam logic [TIMER_W-1:0] OFF_MAX_CYC =
		TIMER_W'(OFF_MAX_US * CLK_MHZ);
	localparam logic [TIMER_W-1:0] ON_MIN_CYC =
		TIMER_W'(ON_MIN_US * CLK_MHZ);
	localparam logic [TIMER_W-1:0] ON_MAX_CYC =
		TIMER_W'(ON_MAX_US * CLK_MHZ);
	localparam logic [TIMER_W-1:0] FORCE_MIN_CYC =
		TIMER_W'(FORCE_MIN_US * CLK_MHZ);
	localparam logic [TIMER_W-1:0] FORCE_MAX_CYC =
		TIMER_W'(FORCE_MAX_US * CLK_MHZ);
	localparam logic [TIMER_W-1:0] PER_MIN_CYC =
		TIMER_W'(PER_MIN_US * CLK_MHZ);
	localparam logic [TIMER_W-1:0] PER_MAX_CYC =
		TIMER_W'(PER_MAX_US * CLK_MHZ);
	localparam logic [TIMER_W-1:0] HOLD_CYC =
		TIMER_W'(HOLD_MS * CLK_MHZ * 1000);
	localparam logic [TIMER_W-1:0] DEBOUNCE_CYC =
		TIMER_W'(DEBOUNCE_MS * CLK_MHZ * 1000);

	// Level thresholds in millivolts
	localparam logic [ADC_W-1:0] LVL_OFF_MAX_MV = ADC_W'(800);
	localparam logic [ADC_W-1:0] LVL_ON_MIN_MV = ADC_W'(2500);
	localparam logic [ADC_W-1:0] LVL_ON_MAX_MV = ADC_W'(3800);
	localparam logic [ADC_W-1:0] LVL_FORCE_MIN_MV = ADC_W'(4400);

	typedef enum logic [1:0] {CMD_NONE, CMD_OFF, CMD_ON, CMD_FORCE} cmd_t;
	typedef enum logic [1:0] {PULL_GND, PULL_HALF, PULL_ON} pull_t;
endpackage : magnet_cmd_pkg

module single_pin_magnet_command_input
	import magnet_cmd_pkg::*;
#(
	parameter logic [TIMER_W-1:0] OFF_MIN = OFF_MIN_CYC,
	parameter logic [TIMER_W-1:0] OFF_MAX = OFF_MAX_CYC,
	parameter logic [TIMER_W-1:0] ON_MIN = ON_MIN_CYC,
	parameter logic [TIMER_W-1:0] ON_MAX = ON_MAX_CYC,
	parameter logic [TIMER_W-1:0] FORCE_MIN = FORCE_MIN_CYC,
	parameter logic [TIMER_W-1:0] FORCE_MAX = FORCE_MAX_CYC,
	parameter logic [TIMER_W-1:0] PER_MIN = PER_MIN_CYC,
	parameter logic [TIMER_W-1:0] PER_MAX = PER_MAX_CYC,
	parameter logic [TIMER_W-1:0] HOLD = HOLD_CYC,
	parameter logic [TIMER_W-1:0] DEBOUNCE = DEBOUNCE_CYC
)(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Command pin, digital view (asynchronous)
	input wire logic cmd_pin,
	// Command pin voltage in millivolts, from the on-chip converter
	input wire logic adc_valid,
	input wire logic [ADC_W-1:0] adc_mv,
	// Fieldbus path in use
	input wire logic fieldbus_active,
	// Magnet state from the power stage
	input wire logic mag_known,
	input wire logic mag_on,
	// Decoded command
	output cmd_t cmd_code,
	output logic cmd_strobe,
	output logic fault_clear,
	output logic pwm_mode,
	// Feedback pull target
	output pull_t pull_sel
);
	// Pin synchroniser and edge detect
	logic pin_s1;
	logic pin_s2;
	logic pin_d;
	logic rise;
	logic fall;

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_d <= 1'b0;
		end
		else
		begin
			pin_s1 <= cmd_pin;
			pin_s2 <= pin_s1;
			pin_d <= pin_s2;
		end
	end

	assign rise = pin_s2 & ~pin_d;
	assign fall = ~pin_s2 & pin_d;

	// Timers
	logic [TIMER_W-1:0] since_rise;
	logic [TIMER_W-1:0] hold_time;
	logic [TIMER_W-1:0] stable_time;
	logic level_changed;
	logic [TIMER_W-1:0] span;

	// Rise cycle counts as high, so span is the exact high time or period
	assign span = since_rise + TIMER_W'(1);

	span_timer #(.W(TIMER_W)) u_rise_timer (
		.clock(clock),
		.rst_b(rst_b),
		.restart(rise),
		.count(since_rise)
	);

	span_timer #(.W(TIMER_W)) u_hold_timer (
		.clock(clock),
		.rst_b(rst_b),
		.restart(cmd_code != CMD_FORCE),
		.count(hold_time)
	);

	span_timer #(.W(TIMER_W)) u_stable_timer (
		.clock(clock),
		.rst_b(rst_b),
		.restart(level_changed),
		.count(stable_time)
	);

	// Carrier detection
	logic next_pwm_mode;

	always_comb
	begin
		next_pwm_mode = pwm_mode;
		if (rise && span >= PER_MIN && span <= PER_MAX)
			next_pwm_mode = 1'b1;
		else if (since_rise > PER_MAX)
			next_pwm_mode = 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			pwm_mode <= 1'b0;
		else
			pwm_mode <= next_pwm_mode;
	end

	// Pulse width classification; high time equals time since rise
	cmd_t pulse_cmd;

	always_comb
	begin
		if (span >= OFF_MIN && span <= OFF_MAX)
			pulse_cmd = CMD_OFF;
		else if (span >= ON_MIN && span <= ON_MAX)
			pulse_cmd = CMD_ON;
		else if (span >= FORCE_MIN && span <= FORCE_MAX)
			pulse_cmd = CMD_FORCE;
		else
			pulse_cmd = CMD_NONE;
	end

	// Level classification and debounce
	cmd_t level_cls;
	cmd_t next_level_cls;
	cmd_t sample_cls;

	always_comb
	begin
		if (adc_mv <= LVL_OFF_MAX_MV)
			sample_cls = CMD_OFF;
		else if (adc_mv >= LVL_ON_MIN_MV && adc_mv <= LVL_ON_MAX_MV)
			sample_cls = CMD_ON;
		else if (adc_mv >= LVL_FORCE_MIN_MV)
			sample_cls = CMD_FORCE;
		else
			sample_cls = CMD_NONE;
	end

	always_comb
	begin
		next_level_cls = level_cls;
		if (adc_valid)
			next_level_cls = sample_cls;
	end

	assign level_changed = next_level_cls != level_cls;

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			level_cls <= CMD_NONE;
		else
			level_cls <= next_level_cls;
	end

	// Candidate command from the active path
	logic cand_valid;
	cmd_t cand_cmd;
	logic level_path;

	// Level path only once the pin has been free of rising edges for a
	// whole slowest carrier period, so pulse trains never feed it
	assign level_path = ~pwm_mode && since_rise > PER_MAX;

	always_comb
	begin
		cand_valid = 1'b0;
		cand_cmd = CMD_NONE;
		if (pwm_mode && fall && pulse_cmd != CMD_NONE)
		begin
			cand_valid = 1'b1;
			cand_cmd = pulse_cmd;
		end
		else if (level_path && stable_time >= DEBOUNCE &&
			level_cls != CMD_NONE)
		begin
			cand_valid = 1'b1;
			cand_cmd = level_cls;
		end
	end

	// Held command, force hold tracking and fault clear
	cmd_t next_cmd_code;
	logic next_cmd_strobe;
	logic next_fault_clear;
	logic force_held;
	logic next_force_held;

	always_comb
	begin
		next_cmd_code = cmd_code;
		next_cmd_strobe = 1'b0;
		next_fault_clear = 1'b0;
		next_force_held = force_held;
		if (cmd_code == CMD_FORCE && hold_time >= HOLD)
			next_force_held = 1'b1;
		if (fieldbus_active)
		begin
			next_force_held = 1'b0;
		end
		else if (cand_valid && cand_cmd != cmd_code)
		begin
			// A floating pin reads back the present state: no change
			next_cmd_code = cand_cmd;
			next_cmd_strobe = 1'b1;
			if (next_force_held && cand_cmd != CMD_FORCE)
				next_fault_clear = 1'b1;
			if (cand_cmd != CMD_FORCE)
				next_force_held = 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			cmd_code <= CMD_NONE;
			cmd_strobe <= 1'b0;
			fault_clear <= 1'b0;
			force_held <= 1'b0;
		end
		else
		begin
			cmd_code <= next_cmd_code;
			cmd_strobe <= next_cmd_strobe;
			fault_clear <= next_fault_clear;
			force_held <= next_force_held;
		end
	end

	// Feedback pull target
	pull_t next_pull_sel;

	always_comb
	begin
		if (!mag_known)
			next_pull_sel = PULL_HALF;
		else if (mag_on)
			next_pull_sel = PULL_ON;
		else
			next_pull_sel = PULL_GND;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			pull_sel <= PULL_HALF;
		else
			pull_sel <= next_pull_sel;
	end
endmodule : single_pin_magnet_command_input

// [core/span_timer.sv]
`timescale 1ns/1ps
module span_timer
	import magnet_cmd_pkg::*;
#(
	parameter int W = TIMER_W
)(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// Control
	input wire logic restart,
	// Elapsed cycles, saturating
	output logic [W-1:0] count
);
	logic [W-1:0] next_count;

	always_comb
	begin
		if (restart)
			next_count = '0;
		else if (&count)
			next_count = count;
		else
			next_count = count + W'(1);
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			count <= '0;
		else
			count <= next_count;
	end
endmodule : span_timer

// [sim/magnet_cmd_checker.sv]
`timescale 1ns/1ps
module magnet_cmd_checker
	import magnet_cmd_pkg::*;
#(
	parameter logic [TIMER_W-1:0] HOLD = HOLD_CYC
)(
	// Watched ports
	input wire logic clock,
	input wire logic rst_b,
	input wire logic cmd_pin,
	input wire logic fieldbus_active,
	input wire logic mag_known,
	input wire logic mag_on,
	input wire cmd_t cmd_code,
	input wire logic cmd_strobe,
	input wire logic fault_clear,
	input wire logic pwm_mode,
	input wire pull_t pull_sel
);
	logic [31:0] fcnt, next_fcnt;
	logic [3:0] age, next_age;
	logic pin_q;
	// Force hold length, cycles since the pin fell
	always_comb
	begin
		next_fcnt = cmd_code == CMD_FORCE && !fieldbus_active ? fcnt + 32'h1 : '0;
		next_age = pin_q && !cmd_pin ? 4'h0 : age + 4'(age != 4'hF);
	end
	always_ff @(posedge clock)
	begin
		fcnt <= next_fcnt;
		age <= next_age;
		pin_q <= cmd_pin;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence s_long_force;
		$past(cmd_code) == CMD_FORCE && $past(fcnt) > HOLD + 4 && cmd_strobe;
	endsequence
	chk_strobe_change:
		assert property (cmd_strobe |-> cmd_code != $past(cmd_code))
		else $error("strobe, no change");
	chk_code_held:
		assert property (!cmd_strobe |-> $stable(cmd_code))
		else $error("silent change");
	chk_bus_quiet:
		assert property ($past(fieldbus_active) |-> !cmd_strobe)
		else $error("strobe on fieldbus");
	chk_clear_pair:
		assert property (fault_clear |->
			cmd_strobe && cmd_code inside {CMD_OFF, CMD_ON})
		else $error("bad clear");
	chk_clear_early:
		assert property (fault_clear |-> $past(fcnt) >= HOLD - 4)
		else $error("early clear");
	chk_clear_due:
		assert property (s_long_force |-> fault_clear)
		else $error("no clear");
	chk_pulse_timing:
		assert property (cmd_strobe && pwm_mode |-> age inside {[1:6]})
		else $error("pulse timing");
	chk_pull_known:
		assert property (mag_known |=>
			pull_sel == ($past(mag_on) ? PULL_ON : PULL_GND))
		else $error("pull level");
	chk_pull_half:
		assert property (!mag_known |=> pull_sel == PULL_HALF)
		else $error("pull not half");
endmodule : magnet_cmd_checker
bind single_pin_magnet_command_input magnet_cmd_checker #(.HOLD(HOLD)) u_chk (
	.clock(clock), .rst_b(rst_b), .cmd_pin(cmd_pin),
	.fieldbus_active(fieldbus_active), .mag_known(mag_known),
	.mag_on(mag_on), .cmd_code(cmd_code), .cmd_strobe(cmd_strobe),
	.fault_clear(fault_clear), .pwm_mode(pwm_mode), .pull_sel(pull_sel));

// [sim/rc_pulse_source.sv]
`timescale 1ns/1ps
module rc_pulse_source
(
	// Control
	input wire logic clock,
	input wire logic en,
	input wire logic [31:0] width,
	input wire logic [31:0] period,
	// Pin
	output logic pin
);
	logic [31:0] phase, next_phase, wid, next_wid;
	// Width is taken only at a period start, so no pulse is cut
	always_comb
	begin
		next_phase = !en || phase >= period - 1 ? '0 : phase + 32'h1;
		next_wid = phase == '0 ? width : wid;
	end
	always_ff @(negedge clock)
	begin
		phase <= next_phase;
		wid <= next_wid;
	end
	assign pin = en && phase < wid;
endmodule : rc_pulse_source

// [sim/test_single_pin_magnet_command_input.sv]
`timescale 1ns/1ps
module test_single_pin_magnet_command_input
	import magnet_cmd_pkg::*;
;
	localparam int PW[6] = '{32'h50, 32'h78, 32'hA0, 32'hBE, 32'hD2, 32'hFA};
	localparam int MV[6] = '{0, 32'h320, 32'h9C4, 32'hED8, 32'h1130, 32'h1FFF};
	logic clock = 0, rst_b = 0, en = 0, adc_valid = 0, fieldbus_active = 0;
	logic mag_known = 0, mag_on = 0, cmd_pin, cmd_strobe, fault_clear, pwm_mode;
	logic [31:0] width = 0, seed = 32'hDFCC;
	logic [ADC_W-1:0] adc_mv = '0;
	cmd_t cmd_code, exp = CMD_NONE;
	pull_t pull_sel;
	int fail_count = 0, total_checks = 0, strobes = 0, clears = 0, s;
	always #2 clock = ~clock;
	always @(posedge clock)
	begin
		strobes <= strobes + int'(cmd_strobe === 1'b1);
		clears <= clears + int'(fault_clear === 1'b1);
	end
	rc_pulse_source u_rc_pulse_source (.clock(clock), .en(en),
		.width(width), .period(32'h190), .pin(cmd_pin));
	single_pin_magnet_command_input #(.OFF_MIN(PW[0]), .OFF_MAX(PW[1]),
		.ON_MIN(PW[2]), .ON_MAX(PW[3]), .FORCE_MIN(PW[4]), .FORCE_MAX(PW[5]),
		.PER_MIN(32'h12C), .PER_MAX(32'h9C4), .HOLD(32'h7D0),
		.DEBOUNCE(32'h32)) u_single_pin_magnet_command_input (
		.clock(clock), .rst_b(rst_b), .cmd_pin(cmd_pin),
		.adc_valid(adc_valid), .adc_mv(adc_mv),
		.fieldbus_active(fieldbus_active), .mag_known(mag_known),
		.mag_on(mag_on), .cmd_code(cmd_code), .cmd_strobe(cmd_strobe),
		.fault_clear(fault_clear), .pwm_mode(pwm_mode), .pull_sel(pull_sel));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	function automatic cmd_t cls(input int v, input int t[6], input cmd_t p);
		for (int k = 0; k < 3; k++)
			if (v >= t[2 * k] && v <= t[2 * k + 1])
				return cmd_t'(k + 1);
		return p;
	endfunction : cls
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want)
		begin
			fail_count++;
			$display("FAIL %0t got %0h want %0h", $time, seen, want);
		end
	endtask : check
	// Pulses when lvl is 0, else n converter samples of v
	task automatic drive(input int v, input int n, input bit lvl);
		width = 32'(v);
		en = !lvl;
		repeat (n)
		begin
			adc_valid = lvl;
			adc_mv = ADC_W'(v);
			@(negedge clock);
			adc_valid = 0;
			repeat (4) @(negedge clock);
		end
	endtask : drive
	// Window edges, two gap values, then random values
	task automatic sweep(input int t[6], input bit lvl);
		int v;
		for (int k = 0; k < 14; k++)
		begin
			seed = lfsr(seed);
			v = k < 6 ? t[k] : k < 8 ? t[2 * k - 11] + 10 :
				lvl ? seed % 32'h1770 : 32'h46 + seed % 32'hC8;
			drive(v, lvl ? 20 : 240, lvl);
			exp = cls(v, t, exp);
			check(cmd_code, exp);
		end
		$display("sweep done");
	endtask : sweep
	task automatic results;
		$display("checks %0d fails %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	initial
	begin
		repeat (4) @(negedge clock);
		rst_b = 1;
		for (int k = 0; k < 3; k++)
		begin
			mag_known = k > 0;
			mag_on = k > 1;
			repeat (2) @(negedge clock);
			check(pull_sel,
				mag_on ? PULL_ON : mag_known ? PULL_GND : PULL_HALF);
		end
		$display("pull done");
		sweep(PW, 0);
		check(pwm_mode, 1);
		fieldbus_active = 1;
		drive(exp == CMD_OFF ? 180 : 100, 240, 0);
		check(cmd_code, exp);
		fieldbus_active = 0;
		$display("fieldbus done");
		s = clears;
		drive(240, 600, 0);
		drive(180, 240, 0);
		check(clears, s + 1);
		drive(240, 160, 0);
		drive(100, 240, 0);
		check(clears, s + 1);
		check(cmd_code, CMD_OFF);
		$display("fault clear done");
		en = 0;
		repeat (2600) @(negedge clock);
		check(pwm_mode, 0);
		sweep(MV, 1);
		drive(3000, 20, 1);
		s = strobes;
		drive(4500, 2, 1);
		drive(3000, 20, 1);
		check(strobes, s);
		drive(3300, 20, 1);
		check(strobes, s);
		check(cmd_code, CMD_ON);
		$display("level done");
		results();
	end
	initial
	begin
		repeat (60000) @(posedge clock);
		fail_count++;
		results();
	end
endmodule : test_single_pin_magnet_command_input
